// *** pkg/occd_pkg.sv ***
// constants and types for the output channel config and divider block
// assumes a 32-bit AHB-Lite bus with word-aligned registers
package occd_pkg;
    localparam int          NUM_CH       = 2;
    localparam int          IDX_LSB      = 2;
    localparam logic [7:0]  IDX_CH0_CTRL = 8'h1f;
    localparam logic [7:0]  IDX_CH1_CTRL = 8'h20;
    localparam logic [7:0]  IDX_DIV      = 8'h21;
    localparam logic [7:0]  IDX_STATUS   = 8'h22;
    localparam int          SEL_LSB      = 5;
    localparam int          MODE1_LSB    = 3;
    localparam int          MODE2_LSB    = 1;
    localparam logic [7:0]  CH0_CTRL_RST = 8'hb0;
    localparam logic [7:0]  CH1_CTRL_RST = 8'h30;
    localparam logic [7:0]  CH0_WMASK    = 8'hfe;
    localparam logic [7:0]  CH1_WMASK    = 8'h7e;
    localparam logic [7:0]  DIV_RST      = 8'h01;
    localparam logic [4:0]  TAIL_MA_0    = 5'h04;
    localparam logic [4:0]  TAIL_MA_1    = 5'h06;
    localparam logic [4:0]  TAIL_MA_2    = 5'h08;
    localparam logic [4:0]  TAIL_MA_HCSL = 5'h10;
    localparam logic [4:0]  TAIL_MA_PECL = 5'h08;
    localparam logic [7:0]  LOAD_OHM_1   = 8'h32;
    localparam logic [7:0]  LOAD_OHM_2   = 8'h64;
    localparam logic [7:0]  LOAD_OHM_3   = 8'hc8;

    typedef enum logic [1:0] {
        OCCD_FMT_OFF  = 2'h0,
        OCCD_FMT_AC   = 2'h1,
        OCCD_FMT_HCSL = 2'h2,
        OCCD_FMT_CMOS = 2'h3
    } occd_fmt_t;

    typedef enum logic [1:0] {
        OCCD_PIN_HIZ  = 2'h0,
        OCCD_PIN_LOW  = 2'h1,
        OCCD_PIN_INV  = 2'h2,
        OCCD_PIN_TRUE = 2'h3
    } occd_pin_t;

    typedef enum logic [1:0] {
        OCCD_BUS_IDLE  = 2'h0,
        OCCD_BUS_WRITE = 2'h1,
        OCCD_BUS_READ  = 2'h3
    } occd_bus_t;
endpackage : occd_pkg

// *** pkg/occd_chan_if.sv ***
// carrier between the register bank and one channel decoder
// assumes the decoder is purely combinational
`timescale 1ns/10ps
interface occd_chan_if;
    logic [7:0]          ctlByte;
    occd_pkg::occd_fmt_t fmt;
    logic [4:0]          tailMa;
    logic [7:0]          loadOhm;
    occd_pkg::occd_pin_t pinP;
    occd_pkg::occd_pin_t pinN;

    modport regs (output ctlByte, input fmt, input tailMa, input loadOhm, input pinP, input pinN);
    modport dec  (input ctlByte, output fmt, output tailMa, output loadOhm, output pinP, output pinN);
endinterface : occd_chan_if

// *** logic/occd_channel_decode.sv ***
// decodes one channel control byte into driver settings
// assumes the byte comes straight from the register bank
`timescale 1ns/10ps
module occd_channel_decode (
    occd_chan_if.dec ch
);
    logic [1:0] mode1;
    logic [1:0] mode2;

    assign mode1 = ch.ctlByte[occd_pkg::MODE1_LSB +: 2];
    assign mode2 = ch.ctlByte[occd_pkg::MODE2_LSB +: 2];

    always_comb begin
        ch.fmt     = occd_pkg::occd_fmt_t'(ch.ctlByte[occd_pkg::SEL_LSB +: 2]);
        ch.tailMa  = 5'h00;
        ch.loadOhm = 8'h00;
        ch.pinP    = occd_pkg::OCCD_PIN_HIZ;
        ch.pinN    = occd_pkg::OCCD_PIN_HIZ;
        unique case (ch.fmt)
            occd_pkg::OCCD_FMT_AC, occd_pkg::OCCD_FMT_HCSL: begin
                unique case (mode1)
                    2'h0: ch.tailMa = occd_pkg::TAIL_MA_0;
                    2'h1: ch.tailMa = occd_pkg::TAIL_MA_1;
                    2'h2: ch.tailMa = occd_pkg::TAIL_MA_2;
                    2'h3: ch.tailMa = (ch.fmt == occd_pkg::OCCD_FMT_HCSL) ?
                                      occd_pkg::TAIL_MA_HCSL : occd_pkg::TAIL_MA_PECL;
                endcase
                if (ch.fmt == occd_pkg::OCCD_FMT_HCSL) begin
                    unique case (mode2)
                        2'h0: ch.loadOhm = 8'h00;
                        2'h1: ch.loadOhm = occd_pkg::LOAD_OHM_1;
                        2'h2: ch.loadOhm = occd_pkg::LOAD_OHM_2;
                        2'h3: ch.loadOhm = occd_pkg::LOAD_OHM_3;
                    endcase
                end
                // tristated hcsl load leaves the pair undriven
                if (ch.fmt == occd_pkg::OCCD_FMT_AC || mode2 != 2'h0) begin
                    ch.pinP = occd_pkg::OCCD_PIN_TRUE;
                    ch.pinN = occd_pkg::OCCD_PIN_INV;
                end
            end
            occd_pkg::OCCD_FMT_CMOS: begin
                ch.pinP = occd_pkg::occd_pin_t'(mode1);
                ch.pinN = occd_pkg::occd_pin_t'(mode2);
            end
            occd_pkg::OCCD_FMT_OFF: begin
                ch.pinP = occd_pkg::OCCD_PIN_HIZ;
            end
        endcase
    end
endmodule : occd_channel_decode

// *** logic/occd_top.sv ***
// register bank and shared divider for output channels 0 and 1
// assumes one AHB-Lite master, single word transfers, hready = hreadyout
`timescale 1ns/10ps
module occd_top (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    output logic [1:0][1:0]           chFormat,
    output logic [1:0][4:0]           chTailMa,
    output logic [1:0][7:0]           chLoadOhm,
    output logic [1:0]                chOutP,
    output logic [1:0]                chOutPOeN,
    output logic [1:0]                chOutN,
    output logic [1:0]                chOutNOeN,
    output logic                      divClk,
    output logic                      divTick
);
    occd_pkg::occd_bus_t busState_reg;
    logic [7:0]          addrIdx_reg;
    logic [7:0]          ch0Ctl_reg;
    logic [7:0]          ch1Ctl_reg;
    logic [7:0]          div_reg;
    logic [7:0]          divCount_reg;
    logic [7:0]          divCount_next;
    logic                divClk_reg;
    logic                divTick_reg;
    logic                hreadyout_reg;
    logic [31:0]         hrdata_reg;
    logic [31:0]         readValue;
    logic [7:0]          reqIdx;
    logic                addrAccept;
    logic                regWrite;
    logic                divWrite;
    logic [8:0]          divHalf;
    logic [1:0][1:0]     chFormat_reg;
    logic [1:0][4:0]     chTailMa_reg;
    logic [1:0][7:0]     chLoadOhm_reg;
    logic [1:0]          chOutP_reg;
    logic [1:0]          chOutPOeN_reg;
    logic [1:0]          chOutN_reg;
    logic [1:0]          chOutNOeN_reg;
    logic [1:0][7:0]     chCtl;

    occd_chan_if chIf[occd_pkg::NUM_CH] ();

    // pin level and active-low enable for one driver state
    function automatic logic [1:0] pinDrive(occd_pkg::occd_pin_t st, logic clk);
        logic [1:0] r;
        r = 2'b10;
        unique case (st)
            occd_pkg::OCCD_PIN_HIZ:  r = 2'b10;
            occd_pkg::OCCD_PIN_LOW:  r = 2'b00;
            occd_pkg::OCCD_PIN_INV:  r = {1'b0, ~clk};
            occd_pkg::OCCD_PIN_TRUE: r = {1'b0, clk};
        endcase
        return r;
    endfunction : pinDrive

    assign chCtl[0]   = ch0Ctl_reg;
    assign chCtl[1]   = ch1Ctl_reg;
    assign reqIdx     = haddr[occd_pkg::IDX_LSB +: 8];
    assign addrAccept = hsel && htrans[1] && hready && (busState_reg != occd_pkg::OCCD_BUS_READ);
    assign regWrite   = (busState_reg == occd_pkg::OCCD_BUS_WRITE);
    assign divWrite   = regWrite && (addrIdx_reg == occd_pkg::IDX_DIV);

    // bus phase tracking; reads take one wait state so hrdata is a flop
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busState_reg  <= occd_pkg::OCCD_BUS_IDLE;
            addrIdx_reg   <= 8'h00;
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= 32'h0000_0000;
        end else begin
            unique case (busState_reg)
                occd_pkg::OCCD_BUS_READ: begin
                    hrdata_reg    <= readValue;
                    hreadyout_reg <= 1'b1;
                    busState_reg  <= occd_pkg::OCCD_BUS_IDLE;
                end
                occd_pkg::OCCD_BUS_IDLE, occd_pkg::OCCD_BUS_WRITE: begin
                    if (addrAccept) begin
                        addrIdx_reg   <= reqIdx;
                        hreadyout_reg <= hwrite;
                        busState_reg  <= hwrite ? occd_pkg::OCCD_BUS_WRITE
                                                : occd_pkg::OCCD_BUS_READ;
                    end else begin
                        busState_reg <= occd_pkg::OCCD_BUS_IDLE;
                    end
                end
                default: begin
                    hreadyout_reg <= 1'b1;
                    busState_reg  <= occd_pkg::OCCD_BUS_IDLE;
                end
            endcase
        end
    end

    // reserved bits are masked off on write so they always read as zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ch0Ctl_reg <= occd_pkg::CH0_CTRL_RST;
        end else if (regWrite && addrIdx_reg == occd_pkg::IDX_CH0_CTRL) begin
            ch0Ctl_reg <= hwdata[7:0] & occd_pkg::CH0_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ch1Ctl_reg <= occd_pkg::CH1_CTRL_RST;
        end else if (regWrite && addrIdx_reg == occd_pkg::IDX_CH1_CTRL) begin
            ch1Ctl_reg <= hwdata[7:0] & occd_pkg::CH1_WMASK;
        end
    end

    // no nonvolatile copy here; reset loads the startup value
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_reg <= occd_pkg::DIV_RST;
        end else if (divWrite) begin
            div_reg <= hwdata[7:0];
        end
    end

    // unmapped words read zero and ignore writes
    always_comb begin
        readValue = 32'h0000_0000;
        unique case (addrIdx_reg)
            occd_pkg::IDX_CH0_CTRL: readValue = {24'h000000, ch0Ctl_reg};
            occd_pkg::IDX_CH1_CTRL: readValue = {24'h000000, ch1Ctl_reg};
            occd_pkg::IDX_DIV:      readValue = {24'h000000, div_reg};
            occd_pkg::IDX_STATUS:   readValue = {23'h000000, divClk_reg, divCount_reg};
            default:                readValue = 32'h0000_0000;
        endcase
    end

    // divider restarts on every divider write so a new ratio starts a clean period
    // high for the larger half of an odd ratio
    assign divHalf = ({1'b0, div_reg} + 9'h002) >> 1;

    always_comb begin
        if (divWrite || divCount_reg == div_reg) begin
            divCount_next = 8'h00;
        end else begin
            divCount_next = divCount_reg + 8'h01;
        end
    end

    // ratio 1 holds divClk high; only divTick shows that rate
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            divCount_reg <= 8'h00;
            divClk_reg   <= 1'b0;
            divTick_reg  <= 1'b0;
        end else begin
            divCount_reg <= divCount_next;
            divClk_reg   <= ({1'b0, divCount_reg} < divHalf);
            divTick_reg  <= (divCount_reg == 8'h00);
        end
    end

    generate
        for (genvar i = 0; i < occd_pkg::NUM_CH; i++) begin : g_ch
            assign chIf[i].ctlByte = chCtl[i];
            occd_channel_decode u_dec (
                .ch (chIf[i].dec)
            );
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    chFormat_reg[i]  <= 2'h0;
                    chTailMa_reg[i]  <= 5'h00;
                    chLoadOhm_reg[i] <= 8'h00;
                    chOutP_reg[i]    <= 1'b0;
                    chOutPOeN_reg[i] <= 1'b1;
                    chOutN_reg[i]    <= 1'b0;
                    chOutNOeN_reg[i] <= 1'b1;
                end else begin
                    chFormat_reg[i]  <= chIf[i].fmt;
                    chTailMa_reg[i]  <= chIf[i].tailMa;
                    chLoadOhm_reg[i] <= chIf[i].loadOhm;
                    {chOutPOeN_reg[i], chOutP_reg[i]} <= pinDrive(chIf[i].pinP, divClk_reg);
                    {chOutNOeN_reg[i], chOutN_reg[i]} <= pinDrive(chIf[i].pinN, divClk_reg);
                end
            end

            a_fmt_follows: assert property (@(posedge sys_clk) disable iff (rst)
                !$past(rst) |-> chFormat[i] == $past(chCtl[i][occd_pkg::SEL_LSB +: 2]))
                else $error("channel format does not follow its control field");

            a_cmos_pos_pin: assert property (@(posedge sys_clk) disable iff (rst)
                (chCtl[i][6:5] == 2'h3 && chCtl[i][4:3] == 2'h3)
                |=> (!chOutPOeN[i] && chOutP[i] == $past(divClk_reg)))
                else $error("cmos positive pin not driven true");

            a_tail_current: assert property (@(posedge sys_clk) disable iff (rst)
                (chCtl[i][6:5] == 2'h2 && chCtl[i][4:3] == 2'h3) |=> chTailMa[i] == 5'h10)
                else $error("hcsl top tail current is not 16 mA");

            a_cmos_neg_pin: assert property (@(posedge sys_clk) disable iff (rst)
                (chCtl[i][6:5] == 2'h3 && chCtl[i][2:1] == 2'h1)
                |=> (!chOutNOeN[i] && !chOutN[i]))
                else $error("cmos negative pin not held low");

            a_hcsl_load: assert property (@(posedge sys_clk) disable iff (rst)
                (chCtl[i][6:5] == 2'h2 && chCtl[i][2:1] == 2'h0)
                |=> (chLoadOhm[i] == 8'h00 && chOutPOeN[i] && chOutNOeN[i]))
                else $error("hcsl tristate load still drives the pair");

            a_off_tristate: assert property (@(posedge sys_clk) disable iff (rst)
                (chCtl[i][6:5] == 2'h0)
                |=> (chOutPOeN[i] && chOutNOeN[i] && chTailMa[i] == 5'h00))
                else $error("disabled channel still drives a pin");

            a_ac_diff_pins: assert property (@(posedge sys_clk) disable iff (rst)
                (chCtl[i][6:5] == 2'h1)
                |=> (!chOutPOeN[i] && !chOutNOeN[i] && chOutP[i] != chOutN[i]))
                else $error("ac differential pair not driven in opposite phase");

            a_cmos_pos_low: assert property (@(posedge sys_clk) disable iff (rst)
                (chCtl[i][6:5] == 2'h3 && chCtl[i][4:3] == 2'h1)
                |=> (!chOutPOeN[i] && !chOutP[i]))
                else $error("cmos positive pin not held low");

            a_tail_low: assert property (@(posedge sys_clk) disable iff (rst)
                (chCtl[i][6] != chCtl[i][5] && chCtl[i][4:3] == 2'h0)
                |=> chTailMa[i] == 5'h04)
                else $error("lowest tail current is not 4 mA");

            a_cmos_neg_true: assert property (@(posedge sys_clk) disable iff (rst)
                (chCtl[i][6:5] == 2'h3 && chCtl[i][2:1] == 2'h3)
                |=> (!chOutNOeN[i] && chOutN[i] == $past(divClk_reg)))
                else $error("cmos negative pin not driven true");

            a_hcsl_load_max: assert property (@(posedge sys_clk) disable iff (rst)
                (chCtl[i][6:5] == 2'h2 && chCtl[i][2:1] == 2'h3)
                |=> chLoadOhm[i] == 8'hc8)
                else $error("hcsl top load is not 200 ohm");
        end
    endgenerate

    assign hreadyout = hreadyout_reg;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;
    assign chFormat  = chFormat_reg;
    assign chTailMa  = chTailMa_reg;
    assign chLoadOhm = chLoadOhm_reg;
    assign chOutP    = chOutP_reg;
    assign chOutPOeN = chOutPOeN_reg;
    assign chOutN    = chOutN_reg;
    assign chOutNOeN = chOutNOeN_reg;
    assign divClk    = divClk_reg;
    assign divTick   = divTick_reg;

    // helper: cycles between divider ticks, valid only without a divider write between
    // the tick right after a write still belongs to the old count, so skip it too
    logic [8:0] tickGap_reg;
    logic       tickGapOk_reg;
    logic       divWriteDly_reg;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tickGap_reg     <= 9'h001;
            tickGapOk_reg   <= 1'b0;
            divWriteDly_reg <= 1'b0;
        end else begin
            tickGap_reg     <= divTick_reg ? 9'h001 : tickGap_reg + 9'h001;
            divWriteDly_reg <= divWrite;
            tickGapOk_reg   <= (divWrite || divWriteDly_reg) ? 1'b0 :
                               (divTick_reg ? 1'b1 : tickGapOk_reg);
        end
    end

    a_div_period: assert property (@(posedge sys_clk) disable iff (rst)
        (divTick_reg && tickGapOk_reg && !divWrite && !$past(divWrite))
        |-> tickGap_reg == {1'b0, div_reg} + 9'h001)
        else $error("divider period is not stored value plus one");

    a_ctrl_reset: assert property (@(posedge sys_clk)
        $past(rst) |-> (ch0Ctl_reg == 8'hb0 && ch1Ctl_reg == 8'h30))
        else $error("channel control reset value wrong");

    a_div_reset: assert property (@(posedge sys_clk)
        $fell(rst) |-> (div_reg == 8'h01 && divCount_reg == 8'h00 && !divTick_reg)
            ##1 (divCount_reg == 8'h01 && divTick_reg))
        else $error("divider does not come out of reset dividing by two");

    a_read_wait: assert property (@(posedge sys_clk) disable iff (rst)
        (addrAccept && !hwrite) |=> !hreadyout ##1 (hreadyout && hresp == 1'b0))
        else $error("read does not answer after one wait state");

    a_write_no_wait: assert property (@(posedge sys_clk) disable iff (rst)
        (addrAccept && hwrite) |=> (hreadyout && hresp == 1'b0))
        else $error("write inserts a wait state");

    a_rdata_holds: assert property (@(posedge sys_clk) disable iff (rst)
        (busState_reg != occd_pkg::OCCD_BUS_READ) |=> $stable(hrdata))
        else $error("read data changes outside a read");

    a_div_restart: assert property (@(posedge sys_clk) disable iff (rst)
        divWrite |=> divCount_reg == 8'h00 ##1 divTick_reg)
        else $error("divider does not restart after a write");
endmodule : occd_top

// *** verification/tb_top.sv ***
// self-checking bench for the output channel config and divider block
// assumes occd_top alone on an AHB-Lite bus, hready looped back from hreadyout
`timescale 1ns/10ps
module tb_top;
    logic                   sys_clk;
    logic                   rst;
    logic                   hsel;
    logic [31:0]            haddr;
    logic [1:0]             htrans;
    logic                   hwrite;
    logic [2:0]             hsize;
    logic [31:0]            hwdata;
    logic                   hreadyout;
    logic                   hresp;
    logic [31:0]            hrdata;
    logic [1:0][1:0]        chFormat;
    logic [1:0][4:0]        chTailMa;
    logic [1:0][7:0]        chLoadOhm;
    logic [1:0]             chOutP;
    logic [1:0]             chOutPOeN;
    logic [1:0]             chOutN;
    logic [1:0]             chOutNOeN;
    logic                   divClk;
    logic                   divTick;
    int                     failures;
    int                     nChecks;
    logic [31:0]            rdVal;

    occd_top u_dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chFormat(chFormat),
        .chTailMa(chTailMa), .chLoadOhm(chLoadOhm), .chOutP(chOutP), .chOutPOeN(chOutPOeN),
        .chOutN(chOutN), .chOutNOeN(chOutNOeN), .divClk(divClk), .divTick(divTick));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        if (failures == 0 && nChecks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] addrOf(input logic [7:0] idx);
        return {22'h0, idx, 2'h0};
    endfunction : addrOf

    // address phase held until hready, then data phase held until hready again
    task automatic busXfer(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= addrOf(idx);
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdVal = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : busXfer

    task automatic regCheck(input logic [7:0] idx, input logic [31:0] exp);
        busXfer(1'b0, idx, 32'h0);
        chk(rdVal, exp);
    endtask : regCheck

    function automatic logic [4:0] tailExp(input logic [1:0] f, input logic [1:0] m);
        if (f == 2'h0 || f == 2'h3) return 5'h00;
        case (m)
            2'h0: return 5'h04;
            2'h1: return 5'h06;
            2'h2: return 5'h08;
            default: return (f == 2'h2) ? 5'h10 : 5'h08;
        endcase
    endfunction : tailExp

    function automatic logic [7:0] loadExp(input logic [1:0] f, input logic [1:0] m);
        if (f != 2'h2) return 8'h00;
        case (m)
            2'h0: return 8'h00;
            2'h1: return 8'h32;
            2'h2: return 8'h64;
            default: return 8'hc8;
        endcase
    endfunction : loadExp

    // a pin follows divClk of the previous cycle
    function automatic logic pinExp(input logic [1:0] m, input logic c);
        return (m == 2'h1) ? 1'b0 : ((m == 2'h2) ? ~c : c);
    endfunction : pinExp

    task automatic pinCheck(input int ch, input logic [1:0] p, input logic [1:0] n);
        logic prevClk;
        @(posedge sys_clk);
        prevClk = divClk;
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            chk({31'h0, chOutPOeN[ch]}, {31'h0, p == 2'h0});
            chk({31'h0, chOutNOeN[ch]}, {31'h0, n == 2'h0});
            if (p != 2'h0) chk({31'h0, chOutP[ch]}, {31'h0, pinExp(p, prevClk)});
            if (n != 2'h0) chk({31'h0, chOutN[ch]}, {31'h0, pinExp(n, prevClk)});
            prevClk = divClk;
        end
    endtask : pinCheck

    task automatic resetCheck();
        regCheck(occd_pkg::IDX_CH0_CTRL, 32'hb0);
        regCheck(occd_pkg::IDX_CH1_CTRL, 32'h30);
        regCheck(occd_pkg::IDX_DIV, 32'h01);
        for (int ch = 0; ch < 2; ch++) begin
            chk({30'h0, chFormat[ch]}, 32'h1);
            chk({27'h0, chTailMa[ch]}, 32'h8);
            chk({24'h0, chLoadOhm[ch]}, 32'h0);
        end
    endtask : resetCheck

    // divClk is high for the larger half of each period
    task automatic divCheck(input logic [7:0] v);
        int cnt;
        int hi;
        busXfer(1'b1, occd_pkg::IDX_DIV, {24'h0, v});
        regCheck(occd_pkg::IDX_DIV, {24'h0, v});
        cnt = 0;
        do begin
            @(posedge sys_clk);
            cnt++;
        end while (divTick !== 1'b1 && cnt < 600);
        cnt = 0;
        hi  = 0;
        do begin
            @(posedge sys_clk);
            cnt++;
            if (divClk === 1'b1) hi++;
        end while (divTick !== 1'b1 && cnt < 600);
        chk(cnt, {24'h0, v} + 32'h1);
        chk(hi, ({24'h0, v} + 32'h2) >> 1);
    endtask : divCheck

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        test_done();
    end

    initial begin
        logic [7:0] b;
        failures = 0;
        nChecks  = 0;
        rst      = 1'b1;
        hsel     = 1'b0;
        haddr    = 32'h0;
        htrans   = 2'h0;
        hwrite   = 1'b0;
        hsize    = 3'h0;
        hwdata   = 32'h0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        resetCheck();
        // reserved bits and unmapped places
        busXfer(1'b1, occd_pkg::IDX_CH0_CTRL, 32'hffffffff);
        regCheck(occd_pkg::IDX_CH0_CTRL, 32'hfe);
        busXfer(1'b1, occd_pkg::IDX_CH1_CTRL, 32'hffffffff);
        regCheck(occd_pkg::IDX_CH1_CTRL, 32'h7e);
        busXfer(1'b1, 8'h23, 32'h5a);
        regCheck(8'h23, 32'h0);
        regCheck(8'h00, 32'h0);
        // every format, mode pair on both channels; reserved bits written as zero
        for (int ch = 0; ch < 2; ch++) begin
            for (int i = 0; i < 64; i++) begin
                b = {1'b0, i[5:4], i[3:2], i[1:0], 1'b0};
                busXfer(1'b1, ch ? occd_pkg::IDX_CH1_CTRL : occd_pkg::IDX_CH0_CTRL, {24'h0, b});
                regCheck(ch ? occd_pkg::IDX_CH1_CTRL : occd_pkg::IDX_CH0_CTRL, {24'h0, b});
                chk({30'h0, chFormat[ch]}, {30'h0, i[5:4]});
                chk({27'h0, chTailMa[ch]}, {27'h0, tailExp(i[5:4], i[3:2])});
                chk({24'h0, chLoadOhm[ch]}, {24'h0, loadExp(i[5:4], i[1:0])});
                if (i[5:4] == 2'h3) pinCheck(ch, i[3:2], i[1:0]);
                if (i[5:4] == 2'h0) chk({31'h0, chOutPOeN[ch] & chOutNOeN[ch]}, 32'h1);
                if (i[5:4] == 2'h1) chk({29'h0, chOutPOeN[ch], chOutNOeN[ch],
                                         chOutP[ch] ^ chOutN[ch]}, 32'h1);
                if (i[5:4] == 2'h2 && i[1:0] == 2'h0) begin
                    chk({31'h0, chOutPOeN[ch] & chOutNOeN[ch]}, 32'h1);
                end
            end
        end
        divCheck(8'h00);
        regCheck(occd_pkg::IDX_STATUS, 32'h100);
        divCheck(8'h01);
        divCheck(8'h04);
        divCheck(8'hff);
        // a second reset in mid-run brings back the startup values
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        resetCheck();
        divCheck(8'h01);
        test_done();
    end
endmodule : tb_top
